// ==== shared/iblc_defines.svh ====
// constants of the in-band loop-code unit: register indices, fields,
// reset values and timing; included by both modules
`ifndef IBLC_DEFINES_SVH
`define IBLC_DEFINES_SVH

// register indices; byte address is four times the index
`define IBLC_IDX_LEN_CTRL 6'h0A
`define IBLC_IDX_TX_LOW 6'h0B
`define IBLC_IDX_TX_HIGH 6'h0C
`define IBLC_IDX_UP_LOW 6'h0D
`define IBLC_IDX_UP_HIGH 6'h0E
`define IBLC_IDX_DN_LOW 6'h0F
`define IBLC_IDX_DN_HIGH 6'h10
`define IBLC_IDX_CTRL 6'h20
`define IBLC_IDX_STATUS 6'h21
`define IBLC_IDX_MASK 6'h22

// field positions
`define IBLC_TXLEN_MSB 7
`define IBLC_TXLEN_LSB 6
`define IBLC_UPLEN_MSB 5
`define IBLC_UPLEN_LSB 3
`define IBLC_DNLEN_MSB 2
`define IBLC_DNLEN_LSB 0
`define IBLC_CTRL_TXEN 3
`define IBLC_STAT_UP 7
`define IBLC_STAT_DN 6

// reset value and writable mask-register bits
`define IBLC_REG_RESET 8'h00
`define IBLC_STAT_MASK 8'hC0

// timing
`define IBLC_CLK_HZ 20000000
`define IBLC_INTEG_MS 48
`define IBLC_INTEG_CYCLES ((`IBLC_INTEG_MS * `IBLC_CLK_HZ) / 1000)
// error budget is the window length shifted right by this amount
`define IBLC_ERR_SHIFT 6

`endif

// ==== shared/iblc_pkg.sv ====
// types of the in-band loop-code unit
// assumes nothing beyond the shared defines
package iblc_pkg;
  typedef enum logic [1:0] {
    IBLC_TX5 = 2'b00,
    IBLC_TX6 = 2'b01,
    IBLC_TX7 = 2'b10,
    IBLC_TX16 = 2'b11
  } iblc_txlen_e;
  typedef enum logic {
    IBLC_HUNT = 1'b0,
    IBLC_TRACK = 1'b1
  } iblc_det_e;
  typedef logic [7:0] iblc_byte_t;
endpackage : iblc_pkg

// ==== tb/iblc_line_partner.sv ====
// remote line equipment model: sends a repeating loop code with periodic
// bit errors on the receive line, or an idle pattern when not sending
`timescale 1ns/1ps
`default_nettype none
module iblc_line_partner (
  // clock
  input wire logic clk_in,
  // control from the bench
  input wire logic send_in,
  input wire logic [15:0] pat_in,
  input wire logic [4:0] len_in,
  input wire logic [7:0] err_every_in,
  // line
  output logic rx_bit_out
);
  logic [4:0] phase_reg;
  logic [7:0] err_reg;
  initial rx_bit_out = 1'b0;
  always @(posedge clk_in)
  begin
    if (send_in)
    begin
      // code held without a gap for as long as asked
      rx_bit_out <= pat_in[15 - phase_reg] ^ (err_reg == err_every_in - 8'h01);
      phase_reg <= (phase_reg == len_in - 5'h01) ? 5'h00 : phase_reg + 5'h01;
      err_reg <= (err_reg == err_every_in - 8'h01) ? 8'h00 : err_reg + 8'h01;
    end
    else
    begin
      // idle line changes every bit so no stale code lingers
      rx_bit_out <= ~rx_bit_out;
      phase_reg <= 5'h00;
      err_reg <= 8'h00;
    end
  end
endmodule : iblc_line_partner
`default_nettype wire

// ==== tb/inband_loop_code_gen_detect_tb_top.sv ====
// self-checking bench for the in-band loop-code unit
// assumes the remote line model drives the receive line
`timescale 1ns/1ps
`default_nettype none
module inband_loop_code_gen_detect_tb_top;
  typedef struct {logic [7:0] ctl; logic [7:0] lo; logic [7:0] hi; logic [15:0] pat; int n;}
    iblc_txrow_s;
  // length control, low, high, expected repetition msb first, length
  iblc_txrow_s rows [6] = '{
    '{8'h00, 8'h87, 8'h00, 16'h8000, 5},
    '{8'h00, 8'h80, 8'h00, 16'h8000, 5},
    '{8'h40, 8'hA7, 8'h00, 16'hA400, 6},
    '{8'h80, 8'h5B, 8'h00, 16'h5A00, 7},
    '{8'hC0, 8'hC3, 8'h5A, 16'hC35A, 16},
    '{8'hC0, 8'h96, 8'h96, 16'h9696, 16}};
  logic clk, srst, psel, pen, pwr, txi, txi_d, send, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  logic [15:0] pat;
  logic [4:0] len;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, txo, rxb, irq;
  int error_cnt = 0;
  int total_checks = 0;
  int k;

  iblc_top #(.INTEG_CYCLES(256)) dut (.CLOCK_IN(clk), .SRST_IN(srst), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .TX_DATA_IN(txi),
    .TX_DATA_OUT(txo), .RX_DATA_IN(rxb), .IRQ_OUT(irq));
  iblc_line_partner line (.clk_in(clk), .send_in(send), .pat_in(pat), .len_in(len),
    .err_every_in(8'h64), .rx_bit_out(rxb));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // outgoing payload alternates so a stuck code shows up at once
  always @(posedge clk)
  begin
    txi <= ~txi;
    txi_d <= txi;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // one apb transfer; returns in the time step of the completing edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n == 20)
    begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : apb

  task automatic wait_status(input logic [7:0] exp);
    int n;
    for (n = 0; n < 600; n++)
    begin
      apb(1'b0, 8'h84, 32'h0);
      if (rd[7:0] === exp)
        break;
      repeat (14) @(posedge clk);
    end
    check(rd, {24'h0, exp});
    if (n == 600)
      tally_and_finish();
  endtask : wait_status

  initial
  begin
    srst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    txi = 1'b0;
    send = 1'b0;
    pat = 16'h0000;
    len = 5'h01;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, 8'h28, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h84, 32'h0);
    check(rd, 32'h0);
    $display("test reset values done");
    foreach (rows[i])
    begin
      apb(1'b1, 8'h28, {24'h0, rows[i].ctl});
      apb(1'b1, 8'h2C, {24'h0, rows[i].lo});
      apb(1'b1, 8'h30, {24'h0, rows[i].hi});
      apb(1'b1, 8'h80, 32'h08);
      for (k = 0; k < 2 * rows[i].n; k++)
      begin
        @(posedge clk);
        #1;
        check({31'h0, txo}, {31'h0, rows[i].pat[15 - k % rows[i].n]});
      end
      apb(1'b1, 8'h80, 32'h00);
      @(posedge clk);
      for (k = 0; k < 4; k++)
      begin
        @(posedge clk);
        #1;
        check({31'h0, txo}, {31'h0, txi_d});
      end
      $display("test transmit row %0d done", i);
    end
    // awkward cases: unmapped access, detection, masking, clearing
    apb(1'b0, 8'hFC, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, 8'h88, 32'h40);
    apb(1'b1, 8'h28, 32'h27);
    apb(1'b0, 8'h28, 32'h0);
    check(rd, 32'h27);
    apb(1'b1, 8'h34, 32'h80);
    apb(1'b1, 8'h38, 32'h00);
    apb(1'b1, 8'h3C, 32'hE4);
    apb(1'b1, 8'h40, 32'h2B);
    pat <= 16'h8000;
    len <= 5'h05;
    send <= 1'b1;
    repeat (150) @(posedge clk);
    apb(1'b0, 8'h84, 32'h0);
    check(rd, 32'h0);
    wait_status(8'h80);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, 8'h88, 32'hC0);
    #1;
    check({31'h0, irq}, 32'h1);
    @(posedge clk);
    send <= 1'b0;
    repeat (20) @(posedge clk);
    apb(1'b1, 8'h84, 32'h80);
    apb(1'b0, 8'h84, 32'h0);
    check({31'h0, irq}, 32'h0);
    check(rd, 32'h0);
    $display("test loop-up detect done");
    pat <= 16'hE42B;
    len <= 5'h10;
    send <= 1'b1;
    wait_status(8'h40);
    check({31'h0, irq}, 32'h1);
    send <= 1'b0;
    $display("test loop-down detect done");
    tally_and_finish();
  end
endmodule : inband_loop_code_gen_detect_tb_top
`default_nettype wire

// ==== verilog/iblc_detector.sv ====
// one repeating-code detector, one line bit per clock
// assumes received bits arrive synchronous to clk_in, one per cycle
`timescale 1ns/1ps
`default_nettype none
`include "iblc_defines.svh"
module iblc_detector #(
  parameter int INTEG_CYCLES = `IBLC_INTEG_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // line and configuration
  input wire logic rx_bit_in,
  input wire logic [2:0] len_sel_in,
  input wire iblc_pkg::iblc_byte_t pat_first_in,
  input wire iblc_pkg::iblc_byte_t pat_second_in,
  // result
  output logic found_out,
  output logic locked_out
);
  localparam logic [19:0] WIN_LAST = 20'(INTEG_CYCLES - 1);
  localparam logic [19:0] ERR_LIMIT = WIN_LAST >> `IBLC_ERR_SHIFT;

  logic [3:0] phase_reg;
  logic [19:0] win_reg;
  logic [19:0] errs_reg;
  logic found_reg;
  iblc_pkg::iblc_det_e state_reg;
  logic [3:0] len_m1;
  logic [15:0] pattern;
  logic expect_bit;
  logic mism;
  logic slip;
  logic [3:0] phase_next;

  // 000..110 give 1..7 bits, 111 gives 16; 8 repeats inside 16
  assign len_m1 = (len_sel_in == 3'h7) ? 4'hF : {1'b0, len_sel_in};
  // first register bit 7 is the first bit, unused low bits never reached
  assign pattern = {pat_first_in, pat_second_in};
  assign expect_bit = pattern[4'hF - phase_reg];
  assign mism = rx_bit_in ^ expect_bit;
  // too many errors in this window: hold phase one bit to re-align
  assign slip = mism && (errs_reg >= ERR_LIMIT);
  assign phase_next = (phase_reg >= len_m1) ? 4'h0 : phase_reg + 4'h1;

  // errors up to the budget are tolerated, so a 1e-2 line still locks
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      phase_reg <= 4'h0;
      win_reg <= 20'h00000;
      errs_reg <= 20'h00000;
      state_reg <= iblc_pkg::IBLC_HUNT;
      found_reg <= 1'b0;
    end
    else if (slip)
    begin
      win_reg <= 20'h00000;
      errs_reg <= 20'h00000;
      state_reg <= iblc_pkg::IBLC_HUNT;
      found_reg <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_next;
      found_reg <= 1'b0;
      if (win_reg == WIN_LAST)
      begin
        // an integration window within the error budget reports the code
        win_reg <= 20'h00000;
        errs_reg <= 20'h00000;
        state_reg <= iblc_pkg::IBLC_TRACK;
        found_reg <= 1'b1;
      end
      else
      begin
        win_reg <= win_reg + 20'h00001;
        errs_reg <= errs_reg + {19'h00000, mism};
      end
    end
  end

  assign found_out = found_reg;
  assign locked_out = (state_reg == iblc_pkg::IBLC_TRACK);

  chk_len16_wrap: assert property (@(posedge clk_in) disable iff (srst_in)
    len_sel_in == 3'h7 && phase_reg == 4'hF && !slip |=> phase_reg == 4'h0)
    else $error("sixteen-bit phase did not wrap");
  chk_good_bit_keeps: assert property (@(posedge clk_in) disable iff (srst_in)
    !mism && state_reg == iblc_pkg::IBLC_TRACK |=> state_reg == iblc_pkg::IBLC_TRACK)
    else $error("matching bit dropped lock");
  chk_found_single: assert property (@(posedge clk_in) disable iff (srst_in)
    found_reg |=> !found_reg && state_reg == iblc_pkg::IBLC_TRACK)
    else $error("found pulse too long");
endmodule : iblc_detector
`default_nettype wire

// ==== verilog/iblc_top.sv ====
// in-band loop-code unit: APB registers, transmit code generator,
// loop-up and loop-down detectors, sticky status with interrupt
// assumes line bits move one per CLOCK_IN cycle in both directions
//
// Summary of operation
// - generates and detects repeating patterns of 1 to 8 or 16 bits
// - transmit length field: 00=5, 01=6/3, 10=7, 11=16/8/4/2/1 bits
// - code is sent only while the transmit enable bit is set
// - bit 7 of the low pattern register goes first, then descending
// - low bits beyond the selected 5, 6 or 7 bit length are ignored
// - 80h with 5-bit length gives the repeating CSU code 10000
// - two independent detectors, loop-up and loop-down, own registers
// - receive length 000..110 means 1..7 bits, 111 means 16/8 bits
// - length control: tx in 7:6, loop-up in 5:3, loop-down in 2:0
// - detection survives a bit-error rate up to one in a hundred
// - about 48 ms of code sets status bit 7 (up) or 6 (down)
// - loop-up bit 7 is first; low bits ignored for shorter lengths
`timescale 1ns/1ps
`default_nettype none
`include "iblc_defines.svh"
module iblc_top #(
  parameter int INTEG_CYCLES = `IBLC_INTEG_CYCLES
) (
  // clock and reset
  input wire logic CLOCK_IN,
  input wire logic SRST_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // line data
  input wire logic TX_DATA_IN,
  output logic TX_DATA_OUT,
  input wire logic RX_DATA_IN,
  // interrupt
  output logic IRQ_OUT
);
  iblc_pkg::iblc_byte_t len_ctrl_reg;
  iblc_pkg::iblc_byte_t tx_low_reg;
  iblc_pkg::iblc_byte_t tx_high_reg;
  iblc_pkg::iblc_byte_t up_low_reg;
  iblc_pkg::iblc_byte_t up_high_reg;
  iblc_pkg::iblc_byte_t dn_low_reg;
  iblc_pkg::iblc_byte_t dn_high_reg;
  iblc_pkg::iblc_byte_t ctrl_reg;
  iblc_pkg::iblc_byte_t stat_reg;
  iblc_pkg::iblc_byte_t mask_reg;
  iblc_pkg::iblc_byte_t stat_next;
  iblc_pkg::iblc_byte_t rd_byte;
  logic [31:0] prdata_reg;
  logic [5:0] reg_idx;
  logic addr_hit;
  logic wr_en;
  logic setup;
  logic w1c_up;
  logic w1c_dn;

  // transmit side
  iblc_pkg::iblc_txlen_e tx_len;
  logic tx_en;
  logic [3:0] tx_len_m1;
  logic [3:0] tx_idx_reg;
  logic [15:0] tx_pattern;
  logic tx_code_bit;
  logic tx_out_reg;

  // receive side
  logic up_found;
  logic dn_found;
  logic up_locked;
  logic dn_locked;

  // ---------------- apb slave ----------------
  assign reg_idx = PADDR_IN[7:2];
  assign setup = PSEL_IN && !PENABLE_IN;
  assign wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN && addr_hit;

  always_comb
  begin
    addr_hit = 1'b1;
    rd_byte = 8'h00;
    unique case (reg_idx)
      `IBLC_IDX_LEN_CTRL: rd_byte = len_ctrl_reg;
      `IBLC_IDX_TX_LOW: rd_byte = tx_low_reg;
      `IBLC_IDX_TX_HIGH: rd_byte = tx_high_reg;
      `IBLC_IDX_UP_LOW: rd_byte = up_low_reg;
      `IBLC_IDX_UP_HIGH: rd_byte = up_high_reg;
      `IBLC_IDX_DN_LOW: rd_byte = dn_low_reg;
      `IBLC_IDX_DN_HIGH: rd_byte = dn_high_reg;
      `IBLC_IDX_CTRL: rd_byte = ctrl_reg;
      `IBLC_IDX_STATUS: rd_byte = stat_reg;
      `IBLC_IDX_MASK: rd_byte = mask_reg;
      default: addr_hit = 1'b0;
    endcase
  end

  // read data is captured in the setup cycle so the access cycle
  // can complete with no wait state and data straight from flops
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      prdata_reg <= 32'h00000000;
    end
    else if (setup)
    begin
      prdata_reg <= {24'h000000, rd_byte};
    end
  end

  assign PRDATA_OUT = prdata_reg;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !addr_hit;

  // configuration registers
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      len_ctrl_reg <= `IBLC_REG_RESET;
      tx_low_reg <= `IBLC_REG_RESET;
      tx_high_reg <= `IBLC_REG_RESET;
      up_low_reg <= `IBLC_REG_RESET;
      up_high_reg <= `IBLC_REG_RESET;
      dn_low_reg <= `IBLC_REG_RESET;
      dn_high_reg <= `IBLC_REG_RESET;
      ctrl_reg <= `IBLC_REG_RESET;
      mask_reg <= `IBLC_REG_RESET;
    end
    else if (wr_en)
    begin
      unique case (reg_idx)
        `IBLC_IDX_LEN_CTRL: len_ctrl_reg <= PWDATA_IN[7:0];
        `IBLC_IDX_TX_LOW: tx_low_reg <= PWDATA_IN[7:0];
        `IBLC_IDX_TX_HIGH: tx_high_reg <= PWDATA_IN[7:0];
        `IBLC_IDX_UP_LOW: up_low_reg <= PWDATA_IN[7:0];
        `IBLC_IDX_UP_HIGH: up_high_reg <= PWDATA_IN[7:0];
        `IBLC_IDX_DN_LOW: dn_low_reg <= PWDATA_IN[7:0];
        `IBLC_IDX_DN_HIGH: dn_high_reg <= PWDATA_IN[7:0];
        `IBLC_IDX_CTRL: ctrl_reg <= PWDATA_IN[7:0];
        `IBLC_IDX_MASK: mask_reg <= PWDATA_IN[7:0] & `IBLC_STAT_MASK;
        default:
        begin
        end
      endcase
    end
  end

  // ---------------- status and interrupt ----------------
  assign w1c_up = wr_en && reg_idx == `IBLC_IDX_STATUS && PWDATA_IN[`IBLC_STAT_UP];
  assign w1c_dn = wr_en && reg_idx == `IBLC_IDX_STATUS && PWDATA_IN[`IBLC_STAT_DN];

  // a detection in the same cycle as a clear keeps the flag set
  always_comb
  begin
    stat_next = stat_reg;
    if (w1c_up)
    begin
      stat_next[`IBLC_STAT_UP] = 1'b0;
    end
    if (w1c_dn)
    begin
      stat_next[`IBLC_STAT_DN] = 1'b0;
    end
    if (up_found)
    begin
      stat_next[`IBLC_STAT_UP] = 1'b1;
    end
    if (dn_found)
    begin
      stat_next[`IBLC_STAT_DN] = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      stat_reg <= `IBLC_REG_RESET;
    end
    else
    begin
      stat_reg <= stat_next;
    end
  end

  assign IRQ_OUT = |(stat_reg & mask_reg);

  // ---------------- transmit generator ----------------
  assign tx_len = iblc_pkg::iblc_txlen_e'(len_ctrl_reg[`IBLC_TXLEN_MSB:`IBLC_TXLEN_LSB]);
  assign tx_en = ctrl_reg[`IBLC_CTRL_TXEN];

  // 6 covers 3, and 16 covers 8/4/2/1, when both registers hold the code
  always_comb
  begin
    unique case (tx_len)
      iblc_pkg::IBLC_TX5: tx_len_m1 = 4'h4;
      iblc_pkg::IBLC_TX6: tx_len_m1 = 4'h5;
      iblc_pkg::IBLC_TX7: tx_len_m1 = 4'h6;
      iblc_pkg::IBLC_TX16: tx_len_m1 = 4'hF;
    endcase
  end

  // low register first, bit 7 leading; high register carries bits 7..0
  assign tx_pattern = {tx_low_reg, tx_high_reg};
  assign tx_code_bit = tx_pattern[4'hF - tx_idx_reg];

  // index restarts at zero whenever the code is off so it opens on bit 7
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN || !tx_en)
    begin
      tx_idx_reg <= 4'h0;
    end
    else if (tx_idx_reg >= tx_len_m1)
    begin
      tx_idx_reg <= 4'h0;
    end
    else
    begin
      tx_idx_reg <= tx_idx_reg + 4'h1;
    end
  end

  // with the enable off the line data passes untouched
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      tx_out_reg <= 1'b0;
    end
    else
    begin
      tx_out_reg <= tx_en ? tx_code_bit : TX_DATA_IN;
    end
  end

  assign TX_DATA_OUT = tx_out_reg;

  // ---------------- receive detectors ----------------
  // each code has its own pattern pair and length field
  iblc_detector #(
    .INTEG_CYCLES(INTEG_CYCLES)
  ) u_detect_up (
    .clk_in(CLOCK_IN),
    .srst_in(SRST_IN),
    .rx_bit_in(RX_DATA_IN),
    .len_sel_in(len_ctrl_reg[`IBLC_UPLEN_MSB:`IBLC_UPLEN_LSB]),
    .pat_first_in(up_low_reg),
    .pat_second_in(up_high_reg),
    .found_out(up_found),
    .locked_out(up_locked)
  );

  iblc_detector #(
    .INTEG_CYCLES(INTEG_CYCLES)
  ) u_detect_dn (
    .clk_in(CLOCK_IN),
    .srst_in(SRST_IN),
    .rx_bit_in(RX_DATA_IN),
    .len_sel_in(len_ctrl_reg[`IBLC_DNLEN_MSB:`IBLC_DNLEN_LSB]),
    .pat_first_in(dn_low_reg),
    .pat_second_in(dn_high_reg),
    .found_out(dn_found),
    .locked_out(dn_locked)
  );

  // ---------------- checks ----------------
  chk_tx_passthru: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    !tx_en |=> TX_DATA_OUT == $past(TX_DATA_IN))
    else $error("line data not passed while code off");
  chk_tx_first_bit: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    tx_en && tx_idx_reg == 4'h0 |=> TX_DATA_OUT == $past(tx_low_reg[7]))
    else $error("first code bit is not low bit 7");
  chk_tx_high_bit: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    tx_en && tx_len == iblc_pkg::IBLC_TX16 && tx_idx_reg == 4'h8
    |=> TX_DATA_OUT == $past(tx_high_reg[7]))
    else $error("ninth code bit is not high bit 7");
  chk_tx_len_five: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    tx_en && tx_len == iblc_pkg::IBLC_TX5 && $stable(len_ctrl_reg) && tx_idx_reg <= 4'h4
    |=> tx_idx_reg <= 4'h4)
    else $error("five-bit code reached ignored bits");
  chk_tx_wrap: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    tx_en && tx_idx_reg == tx_len_m1 ##1 tx_en |-> tx_idx_reg == 4'h0)
    else $error("code index did not wrap");
  chk_csu_code: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    tx_en && tx_low_reg == 8'h80 && tx_len == iblc_pkg::IBLC_TX5 && tx_idx_reg != 4'h0
    |=> TX_DATA_OUT == 1'b0)
    else $error("csu code carries a stray one");
  chk_flag_set_wins: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    up_found || dn_found |=> (stat_reg & {$past(up_found), $past(dn_found), 6'h00}) != 8'h00)
    else $error("detection lost against a clear");
  chk_irq_follows: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (up_found && mask_reg[`IBLC_STAT_UP] || dn_found && mask_reg[`IBLC_STAT_DN])
    && $stable(mask_reg) ##1 $stable(mask_reg) |-> IRQ_OUT)
    else $error("masked-in detection gave no interrupt");
endmodule : iblc_top
`default_nettype wire
